// [src/mmu_pkg.sv]
package mmu_pkg;
  // register byte addresses
  localparam logic [11:0] BASE_OFS = 12'h000;
  localparam logic [11:0] DESC_OFS = 12'h100;
  localparam logic [11:0] CSR_OFS = 12'h200;
  localparam logic [11:0] SEN_OFS = 12'h204;
  // control/status field positions
  localparam int CSR_EN = 0;
  localparam int CSR_PAGE_LO = 1;
  localparam int CSR_SPACE = 4;
  localparam int CSR_MODE_LO = 5;
  localparam int CSR_TRAP_EN = 9;
  localparam int CSR_TRAPPED = 12;
  localparam int CSR_RDONLY = 13;
  localparam int CSR_NONRES = 15;
  // descriptor field positions
  localparam int DESC_A = 7;
  localparam int DESC_W = 6;
  // space enable bits (user is bit 0)
  localparam int SEN_USER = 0;
  localparam int SEN_SUPER = 1;
  localparam int SEN_KERNEL = 2;
  localparam int PAGES = 48;
  localparam int BASE_SHIFT = 6;
  // reset values
  localparam logic [15:0] CSR_RST = 16'h0000;
  localparam logic [2:0] SEN_RST = 3'h0;
  localparam logic [15:0] DESC_RST = 16'h0000;
  localparam logic [11:0] BASE_RST = 12'h000;
  // processor modes
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPER = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h3;
  // reference kinds
  localparam logic [2:0] REF_FETCH = 3'h0;
  localparam logic [2:0] REF_ISTREAM = 3'h1;
  localparam logic [2:0] REF_DATA = 3'h2;
  localparam logic [2:0] REF_INDIRECT = 3'h3;
  localparam logic [2:0] REF_VECTOR = 3'h4;
  // access keys
  localparam logic [2:0] KEY_RO_TRAP = 3'h1;
  localparam logic [2:0] KEY_RO = 3'h2;
  localparam logic [2:0] KEY_RW_TRAP = 3'h4;
  localparam logic [2:0] KEY_RW_WTRAP = 3'h5;
  localparam logic [2:0] KEY_RW = 3'h6;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [src/page_relocation_space_select.sv]
`timescale 1ns/1ps
`default_nettype none
module page_relocation_space_select (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic req_valid,
  input wire logic [15:0] req_va,
  input wire logic req_write,
  input wire logic [2:0] req_kind,
  input wire logic [1:0] cur_mode,
  input wire logic [1:0] prev_mode,
  input wire logic use_prev,
  input wire logic prev_ispace,
  input wire logic instr_end,
  input wire logic sys_reset,
  output logic pa_valid,
  output logic [17:0] pa_addr,
  output logic pa_abort,
  output logic trap_req,
  input wire logic dma_valid,
  input wire logic [17:0] dma_addr,
  output logic mem_dma_valid,
  output logic [17:0] mem_dma_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by read and write paths

  // returns {hit kind, index}: 1 base, 2 descriptor, 3 csr/space enable
  function automatic logic [7:0] decode(input logic [11:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a[11:8] == mmu_pkg::BASE_OFS[11:8] && a[7:6] != 2'h3) begin
      r = {2'h1, a[7:2]};
    end else if (a[11:8] == mmu_pkg::DESC_OFS[11:8] && a[7:6] != 2'h3) begin
      r = {2'h2, a[7:2]};
    end else if (a == mmu_pkg::CSR_OFS) begin
      r = 8'hc0;
    end else if (a == mmu_pkg::SEN_OFS) begin
      r = 8'hc1;
    end
    return r;
  endfunction

  // mode to register bank number: kernel 0, super 1, user 2
  function automatic logic [1:0] bank(input logic [1:0] m);
    logic [1:0] b;
    b = 2'h2;
    if (m == mmu_pkg::MODE_KERNEL) begin
      b = 2'h0;
    end else if (m == mmu_pkg::MODE_SUPER) begin
      b = 2'h1;
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [11:0] base_r [mmu_pkg::PAGES]; // page_base_register bank
  logic [11:0] base_nxt [mmu_pkg::PAGES];
  logic [15:0] desc_r [mmu_pkg::PAGES]; // page_descriptor_register bank
  logic [15:0] desc_nxt [mmu_pkg::PAGES];
  logic [15:0] csr_r, csr_nxt; // control_status_register
  logic [2:0] sen_r, sen_nxt; // space_enable_register
  logic captured_r, captured_nxt; // status frozen for this instruction
  logic trap_pend_r, trap_pend_nxt;
  logic trap_req_r, trap_req_nxt;
  logic pa_valid_r, pa_valid_nxt;
  logic [17:0] pa_addr_r, pa_addr_nxt;
  logic pa_abort_r, pa_abort_nxt;
  logic dma_v_r, dma_v_nxt;
  logic [17:0] dma_a_r, dma_a_nxt;
  // bus side
  logic aw_have_r, aw_have_nxt;
  logic [11:0] aw_addr_r, aw_addr_nxt;
  logic w_have_r, w_have_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // reference lookup

  logic [1:0] ref_mode; // mode whose sets map this reference
  logic [1:0] ref_bank;
  logic dsp_on; // data space enabled for that mode
  logic sel_d; // data space set chosen
  logic [5:0] sel_idx;
  logic [2:0] key;
  logic mmu_on;
  logic ab_nonres, ab_rdonly, trap_hit;
  logic [17:0] reloc;

  // space and bank choice, key decode
  always_comb begin
    ref_mode = use_prev ? prev_mode : cur_mode;
    if (req_kind == mmu_pkg::REF_VECTOR) begin
      ref_mode = mmu_pkg::MODE_KERNEL;
    end
    ref_bank = bank(ref_mode);
    case (ref_bank)
      2'h0: dsp_on = sen_r[mmu_pkg::SEN_KERNEL];
      2'h1: dsp_on = sen_r[mmu_pkg::SEN_SUPER];
      default: dsp_on = sen_r[mmu_pkg::SEN_USER];
    endcase
    // fetch and istream words stay in instruction space except under the user override below
    sel_d = dsp_on && !prev_ispace &&
      (req_kind == mmu_pkg::REF_DATA || req_kind == mmu_pkg::REF_INDIRECT);
    // user reading own instruction space: no peeking at execute-only
    if (prev_ispace && cur_mode == mmu_pkg::MODE_USER &&
        prev_mode == mmu_pkg::MODE_USER && sen_r[mmu_pkg::SEN_USER]) begin
      sel_d = 1'b1;
    end
    sel_idx = {ref_bank, sel_d, req_va[15:13]};
    key = desc_r[sel_idx][2:0];
    reloc = {base_r[sel_idx], 6'h00} + {5'h00, req_va[12:0]};
    mmu_on = csr_r[mmu_pkg::CSR_EN];
    ab_nonres = key == 3'h0 || key == 3'h3 || key == 3'h7;
    ab_rdonly = req_write &&
      (key == mmu_pkg::KEY_RO_TRAP || key == mmu_pkg::KEY_RO);
    trap_hit = (key == mmu_pkg::KEY_RO_TRAP && !req_write) ||
      key == mmu_pkg::KEY_RW_TRAP ||
      (key == mmu_pkg::KEY_RW_WTRAP && req_write);
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus write decode

  logic do_write;
  logic [7:0] wdec;
  logic [15:0] wval; // byte-lane merged low half
  always_comb begin
    do_write = aw_have_r && w_have_r && !bvalid_r;
    wdec = decode(aw_addr_r);
    wval = 16'h0000;
    if (w_strb_r[0]) begin
      wval[7:0] = w_data_r[7:0];
    end
    if (w_strb_r[1]) begin
      wval[15:8] = w_data_r[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page registers: software write, then hardware flag set wins
  logic hw_go; // live mapped reference
  always_comb begin
    hw_go = req_valid && mmu_on;
    for (int i = 0; i < mmu_pkg::PAGES; i++) begin
      base_nxt[i] = base_r[i];
      desc_nxt[i] = desc_r[i];
      if (do_write && wdec[5:0] == 6'(i)) begin
        if (wdec[7:6] == 2'h1) begin
          base_nxt[i] = wval[11:0];
        end else if (wdec[7:6] == 2'h2) begin
          desc_nxt[i] = wval;
          desc_nxt[i][mmu_pkg::DESC_A] = 1'b0;
          desc_nxt[i][mmu_pkg::DESC_W] = 1'b0;
        end
      end
      if (hw_go && sel_idx == 6'(i)) begin
        if (trap_hit) begin
          desc_nxt[i][mmu_pkg::DESC_A] = 1'b1;
        end
        if (req_write && !ab_nonres && !ab_rdonly) begin
          desc_nxt[i][mmu_pkg::DESC_W] = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, status, trap and translated address
  always_comb begin
    csr_nxt = csr_r;
    sen_nxt = sen_r;
    captured_nxt = captured_r;
    trap_pend_nxt = trap_pend_r;
    trap_req_nxt = 1'b0;
    pa_valid_nxt = req_valid;
    pa_addr_nxt = {2'h0, req_va};
    pa_abort_nxt = 1'b0;
    dma_v_nxt = dma_valid;
    dma_a_nxt = dma_addr;
    if (do_write && wdec == 8'hc0) begin
      csr_nxt = wval;
      captured_nxt = 1'b0; // software rearms the capture
    end else if (do_write && wdec == 8'hc1) begin
      sen_nxt = wval[2:0];
    end
    if (instr_end) begin
      trap_req_nxt = trap_pend_r;
      trap_pend_nxt = 1'b0;
      captured_nxt = 1'b0;
    end
    if (hw_go) begin
      pa_addr_nxt = reloc;
      pa_abort_nxt = ab_nonres || ab_rdonly;
      if (trap_hit && csr_r[mmu_pkg::CSR_TRAP_EN]) begin
        trap_pend_nxt = !instr_end;
        trap_req_nxt = trap_req_nxt || instr_end;
        csr_nxt[mmu_pkg::CSR_TRAPPED] = 1'b1;
      end
      if (ab_nonres) begin
        csr_nxt[mmu_pkg::CSR_NONRES] = 1'b1;
      end
      if (ab_rdonly) begin
        csr_nxt[mmu_pkg::CSR_RDONLY] = 1'b1;
      end
      // only the first event of the instruction names the page
      if ((ab_nonres || ab_rdonly ||
           (trap_hit && csr_r[mmu_pkg::CSR_TRAP_EN])) && !captured_r) begin
        csr_nxt[mmu_pkg::CSR_MODE_LO+:2] = ref_mode;
        csr_nxt[mmu_pkg::CSR_SPACE] = sel_d;
        csr_nxt[mmu_pkg::CSR_PAGE_LO+:3] = req_va[15:13];
        captured_nxt = 1'b1;
      end
    end
    if (sys_reset) begin
      csr_nxt[mmu_pkg::CSR_EN] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes; one write and one read in flight at most
  logic [7:0] rdec;
  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt = w_have_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rdec = decode(s_axi_araddr);
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wdec == 8'h00 ? mmu_pkg::RESP_SLVERR : mmu_pkg::RESP_OKAY;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = mmu_pkg::RESP_OKAY;
      case (rdec[7:6])
        2'h1: rdata_nxt = {20'h0_0000, base_r[rdec[5:0]]};
        2'h2: rdata_nxt = {16'h0000, desc_r[rdec[5:0]]};
        2'h3: rdata_nxt = rdec[0] ? {29'h0, sen_r} : {16'h0000, csr_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = mmu_pkg::RESP_SLVERR;
        end
      endcase
    end
    // readies drop while a beat is held or its answer waits
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt = !w_have_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < mmu_pkg::PAGES; i++) begin
        base_r[i] <= mmu_pkg::BASE_RST;
        desc_r[i] <= mmu_pkg::DESC_RST;
      end
      csr_r <= mmu_pkg::CSR_RST;
      sen_r <= mmu_pkg::SEN_RST;
      captured_r <= 1'b0;
      trap_pend_r <= 1'b0;
      trap_req_r <= 1'b0;
      pa_valid_r <= 1'b0;
      pa_addr_r <= 18'h0_0000;
      pa_abort_r <= 1'b0;
      dma_v_r <= 1'b0;
      dma_a_r <= 18'h0_0000;
      aw_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else begin
      base_r <= base_nxt;
      desc_r <= desc_nxt;
      csr_r <= csr_nxt;
      sen_r <= sen_nxt;
      captured_r <= captured_nxt;
      trap_pend_r <= trap_pend_nxt;
      trap_req_r <= trap_req_nxt;
      pa_valid_r <= pa_valid_nxt;
      pa_addr_r <= pa_addr_nxt;
      pa_abort_r <= pa_abort_nxt;
      dma_v_r <= dma_v_nxt;
      dma_a_r <= dma_a_nxt;
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r <= w_have_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pa_valid = pa_valid_r;
  assign pa_addr = pa_addr_r;
  assign pa_abort = pa_abort_r;
  assign trap_req = trap_req_r;
  assign mem_dma_valid = dma_v_r;
  assign mem_dma_addr = dma_a_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_dma_pass: assert property (@(posedge clock) disable iff (!rstn)
    dma_valid |=> mem_dma_valid && mem_dma_addr == $past(dma_addr))
    else $error("dma address altered");
  a_off_passthru: assert property (@(posedge clock)
    disable iff (!rstn) req_valid && !mmu_on |=>
    !pa_abort && pa_addr == {2'h0, $past(req_va)})
    else $error("disabled unit changed address");
  a_sysreset_off: assert property (@(posedge clock)
    disable iff (!rstn) sys_reset |=> !csr_r[mmu_pkg::CSR_EN])
    else $error("reset left relocation on");
  a_nonres_abort: assert property (@(posedge clock)
    disable iff (!rstn) hw_go && key == 3'h0 |=>
    pa_abort && csr_r[mmu_pkg::CSR_NONRES])
    else $error("non-resident not aborted");
  a_key2_write: assert property (@(posedge clock) disable iff (!rstn)
    hw_go && req_write && key == mmu_pkg::KEY_RO |=> pa_abort)
    else $error("read-only write not aborted");
  a_key6_free: assert property (@(posedge clock) disable iff (!rstn)
    hw_go && key == mmu_pkg::KEY_RW && !trap_pend_r && !instr_end
    |=> !pa_abort && !trap_pend_r)
    else $error("free page faulted");
  a_trap_end: assert property (@(posedge clock) disable iff (!rstn)
    instr_end && trap_pend_r |=> trap_req ##1 !trap_req)
    else $error("trap not raised at end");
  a_vector_kernel: assert property (@(posedge clock)
    disable iff (!rstn) req_valid && req_kind == mmu_pkg::REF_VECTOR
    |-> sel_idx[5:4] == 2'h0)
    else $error("vector not kernel mapped");
  a_dspace_off: assert property (@(posedge clock) disable iff (!rstn)
    req_valid && !dsp_on && !prev_ispace |-> !sel_d)
    else $error("data space used while off");

endmodule // page_relocation_space_select
`default_nettype wire

// [dv/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// processor core stand-in: issues one reference at a time, ends instructions
module core_model (
  input wire logic clock,
  output logic req_valid,
  output logic [15:0] req_va,
  output logic req_write,
  output logic [2:0] req_kind,
  output logic [1:0] cur_mode,
  output logic [1:0] prev_mode,
  output logic use_prev,
  output logic prev_ispace,
  output logic instr_end,
  input wire logic pa_valid,
  input wire logic [17:0] pa_addr,
  input wire logic pa_abort,
  input wire logic trap_req
);
  // quiet core until the bench asks for a reference
  initial begin
    {req_valid, req_va, req_write, req_kind, cur_mode} = '0;
    {prev_mode, use_prev, prev_ispace, instr_end} = '0;
  end
  // one reference, result one edge later as {valid, abort, address}
  task automatic issue(input logic [15:0] va, input logic wr,
    input logic [2:0] kd, input logic [1:0] cm, input logic [1:0] pm,
    input logic up, input logic pi, output logic [19:0] res);
    {req_va, req_write, req_kind, cur_mode} <= {va, wr, kd, cm};
    {prev_mode, use_prev, prev_ispace} <= {pm, up, pi};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    // released address shows garbage, not the last value
    req_va <= ~va;
    @(posedge clock);
    res = {pa_valid, pa_abort, pa_addr};
  endtask
  // end of instruction; trap request is due one edge after
  task automatic end_instr(output logic t);
    instr_end <= 1'b1;
    @(posedge clock);
    instr_end <= 1'b0;
    @(posedge clock);
    t = trap_req;
  endtask
endmodule // core_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
  compares++; \
  if ((gt) !== (ex)) begin \
    errors++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); \
  end \
end
module tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  // register bus, master side
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // core reference path, driven by the partner
  logic req_valid, req_write, use_prev, prev_ispace, instr_end;
  logic [15:0] req_va;
  logic [2:0] req_kind;
  logic [1:0] cur_mode, prev_mode;
  logic pa_valid, pa_abort, trap_req;
  logic [17:0] pa_addr;
  // dma path and system reset pulse
  logic sys_reset = 1'b0, dma_valid = 1'b0;
  logic [17:0] dma_addr = '0, mem_dma_addr;
  logic mem_dma_valid;
  int errors = 0;
  int compares = 0;
  logic [1:0] modes [3] = '{mmu_pkg::MODE_KERNEL, mmu_pkg::MODE_SUPER,
    mmu_pkg::MODE_USER};

  always #10 clock = ~clock;

  page_relocation_space_select i_page_relocation_space_select (
    .clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .req_valid(req_valid), .req_va(req_va), .req_write(req_write),
    .req_kind(req_kind), .cur_mode(cur_mode), .prev_mode(prev_mode),
    .use_prev(use_prev), .prev_ispace(prev_ispace),
    .instr_end(instr_end), .sys_reset(sys_reset), .pa_valid(pa_valid),
    .pa_addr(pa_addr), .pa_abort(pa_abort), .trap_req(trap_req),
    .dma_valid(dma_valid), .dma_addr(dma_addr),
    .mem_dma_valid(mem_dma_valid), .mem_dma_addr(mem_dma_addr));

  core_model i_core_model (
    .clock(clock), .req_valid(req_valid), .req_va(req_va),
    .req_write(req_write), .req_kind(req_kind), .cur_mode(cur_mode),
    .prev_mode(prev_mode), .use_prev(use_prev),
    .prev_ispace(prev_ispace), .instr_end(instr_end),
    .pa_valid(pa_valid), .pa_addr(pa_addr), .pa_abort(pa_abort),
    .trap_req(trap_req));

  ////////////////////////////////////////
  // verdict, single exit point
  task automatic stop_test();
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // byte address of a base (dsc 0) or descriptor (dsc 1) register
  function automatic logic [11:0] reg_at(input logic dsc, input int b,
    input int d, input int p);
    return (dsc ? mmu_pkg::DESC_OFS : mmu_pkg::BASE_OFS) +
      12'((b * 16 + d * 8 + p) * 4);
  endfunction
  function automatic logic [17:0] phys(input logic [11:0] b,
    input logic [15:0] va);
    return {b, 6'h00} + {5'h00, va[12:0]};
  endfunction
  function automatic logic abort_of(input int k, input logic w);
    return k == 0 || k == 3 || k == 7 || (w && (k == 1 || k == 2));
  endfunction
  function automatic logic trap_of(input int k, input logic w);
    return (k == 1 && !w) || k == 4 || (k == 5 && w);
  endfunction
  // set index bank*2+dspace that a reference should use
  function automatic int set_of(input logic [2:0] kd, input logic [1:0] cm,
    input logic [1:0] pm, input logic up, input logic pi,
    input logic [2:0] sn);
    logic [1:0] m;
    int b;
    logic d;
    m = (kd == mmu_pkg::REF_VECTOR) ? mmu_pkg::MODE_KERNEL : (up ? pm : cm);
    b = (m == mmu_pkg::MODE_KERNEL) ? 0 : (m == mmu_pkg::MODE_SUPER) ? 1 : 2;
    d = (up && pi) ? (cm == mmu_pkg::MODE_USER && pm == mmu_pkg::MODE_USER)
      : (kd == mmu_pkg::REF_DATA || kd == mmu_pkg::REF_INDIRECT);
    return b * 2 + int'(d && sn[2 - b]);
  endfunction

  ////////////////////////////////////////
  // register bus write: aw and w together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [15:0] v,
    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready && s_axi_awvalid)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40)
      errors++;
    @(posedge clock);
  endtask
  // register bus read
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready && s_axi_arvalid)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    if (n >= 40)
      errors++;
    @(posedge clock);
  endtask
  // one reference through a chosen space, page 3 bases are distinct
  task automatic space_case(input logic [2:0] kd, input logic [1:0] cm,
    input logic [1:0] pm, input logic up, input logic pi,
    input logic [2:0] sn);
    logic [1:0] r;
    logic [19:0] res;
    logic [15:0] va;
    logic [19:0] ex;
    va = {3'h3, 13'($urandom)};
    wr(mmu_pkg::SEN_OFS, 16'(sn), r);
    i_core_model.issue(va, 1'b0, kd, cm, pm, up, pi, res);
    ex = {2'b10, phys(12'h100 + 12'(set_of(kd, cm, pm, up, pi, sn)) *
      12'h200, va)};
    `CHK("space", ex, res)
  endtask

  ////////////////////////////////////////
  // watchdog, far beyond the expected twelve hundred or so cycles
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [19:0] res;
    logic [15:0] va;
    logic [17:0] a;
    logic [11:0] bs [8];
    logic [11:0] at [5];
    logic [2:0] kd;
    logic t, ab, tm, nr, up;
    void'($urandom(2799));
    at = '{mmu_pkg::CSR_OFS, mmu_pkg::SEN_OFS, 12'h050, 12'h1bc, 12'h300};
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    // reset values, last address unmapped
    foreach (at[i]) begin
      rd(at[i], d, r);
      `CHK("reset value", 32'h0000_0000, d)
      `CHK("rresp", (i == 4) ? mmu_pkg::RESP_SLVERR : mmu_pkg::RESP_OKAY, r)
    end
    wr(12'h3fc, 16'h1234, r);
    `CHK("bresp", mmu_pkg::RESP_SLVERR, r)
    // unit off: non-resident pages pass untouched
    repeat (4) begin
      va = 16'($urandom);
      i_core_model.issue(va, 1'($urandom), mmu_pkg::REF_DATA,
        mmu_pkg::MODE_USER, mmu_pkg::MODE_USER, 1'b0, 1'b0, res);
      `CHK("unit off", {4'h8, va}, res)
    end
    // every key, read and write, traps off and on
    for (int te = 0; te < 2; te++)
      for (int k = 0; k < 8; k++)
        for (int w = 0; w < 2; w++) begin
          ab = abort_of(k, w[0]);
          tm = trap_of(k, w[0]);
          nr = (k == 0 || k == 3 || k == 7);
          wr(mmu_pkg::CSR_OFS, 16'h0001 | (16'(te) << 9), r);
          wr(reg_at(1, 0, 0, 0), 16'(k), r);
          i_core_model.issue(16'h0046, w[0], mmu_pkg::REF_DATA,
            mmu_pkg::MODE_KERNEL, mmu_pkg::MODE_KERNEL, 1'b0, 1'b0, res);
          `CHK("abort", {1'b1, ab}, res[19:18])
          i_core_model.end_instr(t);
          `CHK("trap", te[0] & tm, t)
          rd(reg_at(1, 0, 0, 0), d, r);
          `CHK("desc", {tm, w[0] & ~ab, 3'h0, 3'(k)}, d[7:0])
          rd(mmu_pkg::CSR_OFS, d, r);
          `CHK("cause", {nr, ab & ~nr, te[0] & tm}, {d[15], d[13:12]})
          wr(reg_at(1, 0, 0, 0), 16'h0f00 | 16'(k), r);
          rd(reg_at(1, 0, 0, 0), d, r);
          `CHK("desc write", 16'h0f00 | 16'(k), d[15:0])
        end
    // two faults in one instruction: first one kept
    wr(mmu_pkg::CSR_OFS, 16'h0001, r);
    i_core_model.issue(16'h2000, 1'b0, mmu_pkg::REF_DATA,
      mmu_pkg::MODE_KERNEL, mmu_pkg::MODE_KERNEL, 1'b0, 1'b0, res);
    i_core_model.issue(16'h4000, 1'b0, mmu_pkg::REF_DATA,
      mmu_pkg::MODE_KERNEL, mmu_pkg::MODE_KERNEL, 1'b0, 1'b0, res);
    rd(mmu_pkg::CSR_OFS, d, r);
    `CHK("capture", 7'h41, {d[15], d[6:1]})
    i_core_model.end_instr(t);
    // kernel instruction space, random bases; page 7 onto the io page
    for (int p = 0; p < 8; p++) begin
      bs[p] = (p == 7) ? 12'hf80 : 12'($urandom);
      wr(reg_at(0, 0, 0, p), 16'(bs[p]), r);
      wr(reg_at(1, 0, 0, p), 16'(mmu_pkg::KEY_RW), r);
    end
    wr(mmu_pkg::CSR_OFS, 16'h0001, r);
    repeat (20) begin
      va = 16'($urandom);
      i_core_model.issue(va, 1'($urandom), mmu_pkg::REF_FETCH,
        mmu_pkg::MODE_KERNEL, mmu_pkg::MODE_KERNEL, 1'b0, 1'b0, res);
      `CHK("relocate", {2'b10, phys(bs[va[15:13]], va)}, res)
    end
    // six sets, page 3 each, distinct bases
    for (int s = 0; s < 6; s++) begin
      wr(reg_at(0, s / 2, s % 2, 3), 16'h0100 + 16'(s) * 16'h0200, r);
      wr(reg_at(1, s / 2, s % 2, 3), 16'(mmu_pkg::KEY_RW), r);
    end
    space_case(mmu_pkg::REF_DATA, mmu_pkg::MODE_USER,
      mmu_pkg::MODE_USER, 1'b1, 1'b1, 3'h1);
    space_case(mmu_pkg::REF_VECTOR, mmu_pkg::MODE_USER,
      mmu_pkg::MODE_USER, 1'b0, 1'b0, 3'h3);
    repeat (24) begin
      kd = 3'($urandom_range(4, 0));
      up = (kd == mmu_pkg::REF_DATA) && 1'($urandom);
      // all three enable bits drawn, so the kernel data set is reached too
      space_case(kd, modes[$urandom_range(2, 0)],
        modes[$urandom_range(2, 0)], up, up & 1'($urandom), 3'($urandom));
    end
    // dma bypasses mapping
    repeat (4) begin
      a = 18'($urandom);
      dma_addr <= a;
      dma_valid <= 1'b1;
      @(posedge clock);
      dma_valid <= 1'b0;
      @(posedge clock);
      `CHK("dma", {1'b1, a}, {mem_dma_valid, mem_dma_addr})
    end
    // system reset instruction drops relocation
    sys_reset <= 1'b1;
    @(posedge clock);
    sys_reset <= 1'b0;
    @(posedge clock);
    va = 16'h6abc;
    i_core_model.issue(va, 1'b1, mmu_pkg::REF_DATA, mmu_pkg::MODE_USER,
      mmu_pkg::MODE_USER, 1'b0, 1'b0, res);
    `CHK("sys reset", {4'h8, va}, res)
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
